// File: dtc_pkg.sv
// Purpose: Shared constants and carrier types for the termination control block
// Assumes: 100 MHz system clock, 32-bit APB register access
// Notes: Latency figures are in link clock cycles

package dtc_pkg;

  // Register byte offsets
  localparam logic [11:0] DTC_CFG_OFFSET = 12'h000;
  localparam logic [11:0] DTC_LAT_OFFSET = 12'h004;
  localparam logic [11:0] DTC_MODE_OFFSET = 12'h008;
  localparam logic [11:0] DTC_STAT_OFFSET = 12'h00C;

  // Configuration register fields
  localparam int DTC_DQ_CODE_LSB = 0;
  localparam int DTC_DQ_EN_BIT = 3;
  localparam int DTC_CA_CODE_LSB = 4;
  localparam logic [7:0] DTC_CFG_RESET = 8'h00;

  // Latency register fields and reset values
  localparam int DTC_ON_LAT_LSB = 0;
  localparam int DTC_OFF_LAT_LSB = 8;
  localparam logic [5:0] DTC_ON_LAT_RESET = 6'h04;
  localparam logic [5:0] DTC_OFF_LAT_RESET = 6'h14;
  localparam logic [5:0] DTC_BL32_EXTRA = 6'h08;

  // Mode register fields
  localparam int DTC_MODE_WRLVL_BIT = 0;
  localparam int DTC_MODE_BL32_BIT = 1;
  localparam int DTC_MODE_PD_BIT = 2;
  localparam int DTC_MODE_SR_BIT = 3;

  // Termination strength codes
  localparam logic [2:0] DTC_CODE_OFF = 3'h0;
  localparam logic [2:0] DTC_CODE_240 = 3'h1;
  localparam logic [2:0] DTC_CODE_40 = 3'h6;

  // Asynchronous turn-on / turn-off windows
  localparam int DTC_CLK_MHZ = 100;
  localparam int DTC_TON_MIN_PS = 1500;
  localparam int DTC_TON_MAX_PS = 3500;
  localparam int DTC_TOFF_MIN_PS = 1500;
  localparam int DTC_TOFF_MAX_PS = 3500;
  localparam int DTC_LINK_PERIOD_PS = 32000;
  // Least times round up, longest round down, floor of one cycle
  localparam int DTC_TON_MIN_CYC =
    ((DTC_TON_MIN_PS + DTC_LINK_PERIOD_PS - 1) / DTC_LINK_PERIOD_PS < 1) ? 1 :
    (DTC_TON_MIN_PS + DTC_LINK_PERIOD_PS - 1) / DTC_LINK_PERIOD_PS;
  localparam int DTC_TON_MAX_CYC =
    (DTC_TON_MAX_PS / DTC_LINK_PERIOD_PS < 1) ? 1 : DTC_TON_MAX_PS / DTC_LINK_PERIOD_PS;

  // Settings handed to the link domain
  typedef struct packed {
    logic [2:0] dqCode;
    logic [2:0] caCode;
    logic dqEnable;
    logic writeLevel;
    logic lowPower;
    logic [5:0] onLat;
    logic [5:0] offLat;
  } dtc_cfg_type;

  // Termination drive to the pads
  typedef struct packed {
    logic [2:0] dqCode;
    logic [2:0] dmiCode;
    logic [2:0] strobeTrueCode;
    logic [2:0] strobeCompCode;
    logic [2:0] caCode;
  } dtc_term_type;

endpackage

// File: dtc_sync.sv
// Purpose: Two-flop level synchroniser into a destination clock
// Assumes: Input changes slowly compared to the destination clock
// Notes: First stage is read only by the second stage
`timescale 1ns/10ps

module dtc_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clock, // Destination clock
  input wire logic srst, // Synchronous reset, destination domain
  input wire logic [WIDTH-1:0] din, // Level from the other domain
  output logic [WIDTH-1:0] dout // Synchronised level
);

  logic [WIDTH-1:0] stage1_r;

  // Two stages; words must only change while stable
  always_ff @(posedge clock) begin
    if (srst) begin
      stage1_r <= '0;
      dout <= '0;
    end else begin
      stage1_r <= din;
      dout <= stage1_r;
    end
  end

endmodule

// File: dtc_termination_control.sv
// Purpose: On-die termination control for data, mask, strobe and command pins
// Assumes: APB on clock; write commands arrive on linkClock from the controller
// Notes: Settings cross as a held snapshot under a request/acknowledge toggle pair
`timescale 1ns/10ps

module dtc_termination_control
  import dtc_pkg::*;
(
  input wire logic clock, // System clock, 100 MHz
  input wire logic srst, // Synchronous reset, active high
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB write
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire logic linkClock, // DRAM command clock from the controller
  input wire logic linkSrst, // Synchronous reset, link domain
  input wire logic casTwo, // Second column command of a write or masked write
  output dtc_term_type termDrive, // Strength codes at the pads
  output logic dataTermOn, // Data-side termination fully on
  output logic dataTermStarting // Data-side termination leaving high impedance
);

  ////////////////////////////////////////////////////////////////////////////
  // Register bus

  logic [7:0] cfg_r;
  logic [5:0] onLat_r;
  logic [5:0] offLat_r;
  logic [3:0] mode_r;
  logic busWrite;
  logic hitCfg;
  logic hitLat;
  logic hitMode;
  logic hitStat;
  logic unmapped;
  logic [1:0] statSync;

  // Zero wait states; unmapped answers with error
  assign busWrite = psel && penable && pwrite;
  assign hitCfg = paddr == DTC_CFG_OFFSET;
  assign hitLat = paddr == DTC_LAT_OFFSET;
  assign hitMode = paddr == DTC_MODE_OFFSET;
  assign hitStat = paddr == DTC_STAT_OFFSET;
  assign unmapped = !(hitCfg || hitLat || hitMode || hitStat);
  assign pready = 1'b1;
  assign pslverr = psel && penable && unmapped;

  // Register writes
  always_ff @(posedge clock) begin
    if (srst) begin
      cfg_r <= DTC_CFG_RESET;
      onLat_r <= DTC_ON_LAT_RESET;
      offLat_r <= DTC_OFF_LAT_RESET;
      mode_r <= 4'h0;
    end else if (busWrite) begin
      if (hitCfg) begin
        cfg_r <= {1'b0, pwdata[6:0]};
      end
      if (hitLat) begin
        onLat_r <= pwdata[DTC_ON_LAT_LSB +: 6];
        offLat_r <= pwdata[DTC_OFF_LAT_LSB +: 6];
      end
      if (hitMode) begin
        mode_r <= pwdata[3:0];
      end
    end
  end

  logic [31:0] rdMux;
  assign rdMux = hitCfg ? {24'h0000_00, cfg_r} :
                 hitLat ? {18'h0_0000, offLat_r, 2'h0, onLat_r} :
                 hitMode ? {28'h000_0000, mode_r} :
                 hitStat ? {30'h0000_0000, statSync} : 32'h0000_0000;

  // Read data registered in the setup cycle
  always_ff @(posedge clock) begin
    if (srst) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rdMux;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Settings toward the link domain

  dtc_cfg_type cfgSys;
  dtc_cfg_type cfgLink;
  logic [5:0] offLatTotal;

  // Burst thirty-two stretches the off latency
  assign offLatTotal = mode_r[DTC_MODE_BL32_BIT] ? offLat_r + DTC_BL32_EXTRA : offLat_r;
  assign cfgSys.dqCode = cfg_r[DTC_DQ_CODE_LSB +: 3];
  assign cfgSys.caCode = cfg_r[DTC_CA_CODE_LSB +: 3];
  assign cfgSys.dqEnable = cfg_r[DTC_DQ_EN_BIT] || (cfg_r[2:0] != DTC_CODE_OFF);
  assign cfgSys.writeLevel = mode_r[DTC_MODE_WRLVL_BIT];
  assign cfgSys.lowPower = mode_r[DTC_MODE_PD_BIT] || mode_r[DTC_MODE_SR_BIT];
  assign cfgSys.onLat = onLat_r;
  assign cfgSys.offLat = offLatTotal;

  // Handshake state for the settings snapshot
  dtc_cfg_type cfgHold_r;
  dtc_cfg_type cfgLink_r;
  logic reqToggle_r;
  logic reqSync;
  logic reqSeen_r;
  logic ackSync;
  logic handIdle;
  logic cfgDirty;

  // A new snapshot waits until the last one is taken, so the held word never moves in flight
  assign handIdle = reqToggle_r == ackSync;
  assign cfgDirty = cfgSys != cfgHold_r;

  // Snapshot and request toggle; reset values differ from the registers, so one goes out
  always_ff @(posedge clock) begin
    if (srst) begin
      cfgHold_r <= '0;
      reqToggle_r <= 1'b0;
    end else if (handIdle && cfgDirty) begin
      cfgHold_r <= cfgSys;
      reqToggle_r <= !reqToggle_r;
    end
  end

  dtc_sync #(.WIDTH(1)) u_reqSync (
    .clock(linkClock),
    .srst(linkSrst),
    .din(reqToggle_r),
    .dout(reqSync)
  );

  // Take the held word once the request shows; a lone link reset may leave codes off
  always_ff @(posedge linkClock) begin
    if (linkSrst) begin
      reqSeen_r <= 1'b0;
      cfgLink_r <= '0;
    end else begin
      reqSeen_r <= reqSync;
      if (reqSync != reqSeen_r) begin
        cfgLink_r <= cfgHold_r;
      end
    end
  end

  assign cfgLink = cfgLink_r;

  dtc_sync #(.WIDTH(1)) u_ackSync (
    .clock(clock),
    .srst(srst),
    .din(reqSeen_r),
    .dout(ackSync)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Link domain latency tracking

  typedef enum logic [1:0] {
    DTC_IDLE = 2'b00,
    DTC_WAIT_ON = 2'b01,
    DTC_ON = 2'b10
  } dtc_state_type;

  dtc_state_type state_r;
  dtc_state_type state_nxt;
  logic casTwoSync;
  logic [5:0] count_r;
  logic [5:0] count_nxt;
  logic termOn_r;
  logic starting_r;
  logic codeValid;

  dtc_sync #(.WIDTH(1)) u_casSync (
    .clock(linkClock),
    .srst(linkSrst),
    .din(casTwo),
    .dout(casTwoSync)
  );

  // Reserved code 111 and 000 both mean off
  assign codeValid = cfgLink.dqCode >= DTC_CODE_240 && cfgLink.dqCode <= DTC_CODE_40;

  // Count from the second column command; a new write restarts the count only while on, not while waiting
  always_comb begin
    state_nxt = state_r;
    count_nxt = count_r + 6'h01;
    unique case (state_r)
      DTC_IDLE: begin
        if (casTwoSync && codeValid && !cfgLink.writeLevel) begin
          state_nxt = DTC_WAIT_ON;
          count_nxt = 6'h01;
        end
      end
      DTC_WAIT_ON: begin
        if (count_r >= cfgLink.onLat) begin
          state_nxt = DTC_ON;
        end
      end
      DTC_ON: begin
        if (casTwoSync) begin
          count_nxt = 6'h01;
        end else if (count_r >= cfgLink.offLat) begin
          state_nxt = DTC_IDLE;
        end
      end
      default: begin
        state_nxt = DTC_IDLE;
      end
    endcase
    if (cfgLink.lowPower || !codeValid) begin
      state_nxt = DTC_IDLE;
    end
  end

  // Pad windows: starting for the minimum, on after the maximum
  always_ff @(posedge linkClock) begin
    if (linkSrst) begin
      state_r <= DTC_IDLE;
      count_r <= 6'h00;
      termOn_r <= 1'b0;
      starting_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      count_r <= count_nxt;
      starting_r <= state_nxt == DTC_ON;
      termOn_r <= starting_r && state_nxt == DTC_ON;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pad strength selection

  logic [2:0] dataCode;
  logic [2:0] strobeCode;
  logic wlStrobe;
  logic dataAllowed;

  // Gate at the pads too, so a mode change cuts data termination in the same cycle
  assign dataAllowed = !cfgLink.writeLevel && !cfgLink.lowPower && codeValid;
  assign wlStrobe = cfgLink.writeLevel && cfgLink.dqEnable && codeValid;
  assign dataCode = (termOn_r && dataAllowed) ? cfgLink.dqCode : DTC_CODE_OFF;
  assign strobeCode = (wlStrobe && !cfgLink.lowPower) ? cfgLink.dqCode : dataCode;

  // Pad codes registered so the outputs are clean
  always_ff @(posedge linkClock) begin
    if (linkSrst) begin
      termDrive <= '0;
      dataTermOn <= 1'b0;
      dataTermStarting <= 1'b0;
    end else begin
      termDrive.dqCode <= dataCode;
      termDrive.dmiCode <= dataCode;
      termDrive.strobeTrueCode <= strobeCode;
      termDrive.strobeCompCode <= strobeCode;
      termDrive.caCode <= (cfgLink.caCode == 3'h7) ? DTC_CODE_OFF : cfgLink.caCode;
      dataTermOn <= termOn_r && dataAllowed;
      dataTermStarting <= starting_r && dataAllowed;
    end
  end

  dtc_sync #(.WIDTH(2)) u_statSync (
    .clock(clock),
    .srst(srst),
    .din({dataTermStarting, dataTermOn}),
    .dout(statSync)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  property p_wl_data_off;
    @(posedge linkClock) disable iff (linkSrst)
    $past(cfgLink.writeLevel) |-> termDrive.dqCode == DTC_CODE_OFF;
  endproperty
  a_wl_data_off: assert property (p_wl_data_off) else $error("data termed in leveling");

  property p_wl_strobe;
    @(posedge linkClock) disable iff (linkSrst)
    $past(wlStrobe && !cfgLink.lowPower) |-> termDrive.strobeTrueCode == $past(cfgLink.dqCode);
  endproperty
  a_wl_strobe: assert property (p_wl_strobe) else $error("strobe not termed in leveling");

  property p_pair;
    @(posedge linkClock) disable iff (linkSrst)
    termDrive.dmiCode == termDrive.dqCode && termDrive.strobeTrueCode == termDrive.strobeCompCode;
  endproperty
  a_pair: assert property (p_pair) else $error("pad codes differ");

  property p_lowpower;
    @(posedge linkClock) disable iff (linkSrst)
    $past(cfgLink.lowPower) |-> termDrive.dqCode == DTC_CODE_OFF;
  endproperty
  a_lowpower: assert property (p_lowpower) else $error("data termed in low power");

  property p_no_early;
    @(posedge linkClock) disable iff (linkSrst)
    (state_r == DTC_WAIT_ON && count_r < cfgLink.onLat) |-> !starting_r;
  endproperty
  a_no_early: assert property (p_no_early) else $error("termination before latency");

  property p_window;
    @(posedge linkClock) disable iff (linkSrst)
    $rose(starting_r) && !cfgLink.lowPower && codeValid |=> termOn_r;
  endproperty
  a_window: assert property (p_window) else $error("turn-on window missed");

  property p_reserved;
    @(posedge linkClock) disable iff (linkSrst)
    !codeValid |=> !starting_r;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved code termed");

  property p_ca;
    @(posedge linkClock) disable iff (linkSrst)
    termDrive.caCode != 3'h7;
  endproperty
  a_ca: assert property (p_ca) else $error("reserved command code driven");

  property p_idle_off;
    @(posedge linkClock) disable iff (linkSrst)
    (state_r == DTC_IDLE) |=> !termOn_r;
  endproperty
  a_idle_off: assert property (p_idle_off) else $error("termination on while idle");

  c_on: cover property (@(posedge linkClock) disable iff (linkSrst) $rose(dataTermOn));
  c_off: cover property (@(posedge linkClock) disable iff (linkSrst) $fell(dataTermOn));
  c_wl: cover property (@(posedge linkClock) disable iff (linkSrst) wlStrobe);

endmodule

// File: dtc_ctrl_model.sv
// Purpose: Memory controller model that issues two-cycle write commands
// Assumes: Link clock runs free, link reset active high
// Notes: Second column command follows the first by one link cycle
`timescale 1ns/10ps

module dtc_ctrl_model (
  input wire logic linkClock, // Command clock
  input wire logic linkSrst, // Link domain reset
  input wire logic writeGo, // Start one write command
  output logic casTwo // Second column command
);
  logic firstCmd_r;

  // First column command, then the second one cycle later; the count starts there
  always_ff @(posedge linkClock) begin
    firstCmd_r <= writeGo & ~linkSrst;
    casTwo <= firstCmd_r & ~linkSrst;
  end
endmodule

// File: dram_termination_control_bench.sv
// Purpose: Self-checking bench for the termination control block
// Assumes: APB on clock, writes arrive on a 32 ns link clock
// Notes: Latencies compared as fixed offsets, so sync delay need not be exact
`timescale 1ns/10ps

module dram_termination_control_bench;
  import dtc_pkg::*;
  logic clock = 0;
  logic srst = 1;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic linkClock = 0;
  logic linkSrst = 1;
  logic writeGo = 0;
  logic casTwo;
  logic dataTermOn;
  logic dataTermStarting;
  dtc_term_type termDrive;
  dtc_term_type atOn;
  int errors = 0;
  int checksDone = 0;

  // Two unrelated clocks
  always #5 clock = ~clock;
  always #16 linkClock = ~linkClock;

  dtc_termination_control uut (.clock(clock), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .linkClock(linkClock), .linkSrst(linkSrst), .casTwo(casTwo),
    .termDrive(termDrive), .dataTermOn(dataTermOn), .dataTermStarting(dataTermStarting));
  dtc_ctrl_model ctrl (.linkClock(linkClock), .linkSrst(linkSrst), .writeGo(writeGo),
    .casTwo(casTwo));

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checksDone++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic close_out;
    if (errors == 0 && checksDone > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // One APB transfer; waits on pready, never on a fixed count
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge clock);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 50);
    check("pready wait", 32'(n), 32'h1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    if (n >= 50) begin
      errors++;
      close_out();
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic err;
    apb(1'b1, a, d, rd, err);
  endtask

  task automatic rdchk(input string what, input logic [11:0] a, input logic [31:0] exp,
                       input logic expErr);
    logic [31:0] rd;
    logic err;
    apb(1'b0, a, '0, rd, err);
    check(what, rd, exp);
    check({what, " err"}, {31'h0, err}, {31'h0, expErr});
  endtask

  // One write; offsets in link cycles counted from the request
  task automatic burst(output int st, output int on, output int fl);
    int n;
    st = -1;
    on = -1;
    fl = -1;
    @(posedge linkClock) writeGo <= 1;
    @(posedge linkClock) writeGo <= 0;
    // Sample on the falling edge, clear of the launching edge
    for (n = 0; n < 120 && fl < 0; n++) begin
      @(negedge linkClock);
      if (st < 0 && dataTermStarting === 1'b1) st = n;
      if (on < 0 && dataTermOn === 1'b1) begin
        on = n;
        atOn = termDrive;
      end
      if (st >= 0 && dataTermStarting !== 1'b1 && dataTermOn !== 1'b1) fl = n;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog, several times the expected run length
  initial begin
    #300_000;
    errors++;
    close_out();
  end

  // Main sequence
  initial begin
    int st, on, fl, baseOn, baseOff, onLat, offLat;
    logic [2:0] c;
    logic bl32;
    static logic [31:0] cfgT[5] = '{32'h0000_003B, 32'h0000_0000, 32'h0000_003B, 32'h0000_003B,
                             32'h0000_007F};
    static logic [31:0] modeT[5] = '{32'h0000_0001, 32'h0000_0001, 32'h0000_0004, 32'h0000_0008,
                              32'h0000_0000};
    static logic [2:0] strT[5] = '{3'h3, 3'h0, 3'h0, 3'h0, 3'h0};
    static logic [2:0] caT[5] = '{3'h3, 3'h0, 3'h3, 3'h3, 3'h0};
    void'($urandom(39504));
    repeat (10) @(posedge clock);
    srst <= 0;
    @(posedge linkClock) linkSrst <= 0;
    rdchk("cfg reset", DTC_CFG_OFFSET, 32'h0, 1'b0);
    rdchk("lat reset", DTC_LAT_OFFSET, {18'h0, DTC_OFF_LAT_RESET, 2'b0, DTC_ON_LAT_RESET}, 1'b0);
    rdchk("mode reset", DTC_MODE_OFFSET, 32'h0, 1'b0);
    rdchk("unmapped", 12'h010, 32'h0, 1'b1);
    wr(DTC_STAT_OFFSET, 32'h0000_000F);
    rdchk("stat", DTC_STAT_OFFSET, 32'h0, 1'b0);
    check("idle dq", 32'(termDrive.dqCode), 32'h0);
    // Every strength code, then random codes, latencies and bursts
    for (int i = 0; i < 14; i++) begin
      c = (i < 6) ? 3'(i + 1) : 3'($urandom_range(1, 6));
      onLat = $urandom_range(2, 12);
      offLat = onLat + $urandom_range(8, 20);
      bl32 = (i < 2) ? i[0] : 1'($urandom_range(0, 1));
      wr(DTC_CFG_OFFSET, {25'h0, c, 1'b1, c});
      wr(DTC_LAT_OFFSET, 32'((offLat << 8) | onLat));
      wr(DTC_MODE_OFFSET, {30'h0, bl32, 1'b0});
      repeat (12) @(posedge linkClock);
      check("idle on", {31'h0, dataTermOn}, 32'h0);
      check("ca code", 32'(termDrive.caCode), 32'(c));
      burst(st, on, fl);
      if (i == 0) begin
        baseOn = st - onLat;
        baseOff = fl - offLat;
        check("on offset", 32'(baseOn >= 1 && baseOn <= 6), 32'h1);
        check("off base", 32'(baseOff), 32'(baseOn));
      end
      check("on latency", 32'(st - onLat), 32'(baseOn));
      check("off latency", 32'(fl - offLat - 8 * bl32), 32'(baseOff));
      check("full on", 32'(on - st), 32'h1);
      check("dq code", 32'(atOn.dqCode), 32'(c));
      check("mask code", 32'(atOn.dmiCode), 32'(c));
      check("strobe codes", 32'({atOn.strobeTrueCode, atOn.strobeCompCode}), 32'({c, c}));
      check("idle after", 32'(termDrive.dqCode), 32'h0);
    end
    // Leveling on and off, power-down, self-refresh, reserved code
    for (int k = 0; k < 5; k++) begin
      wr(DTC_CFG_OFFSET, cfgT[k]);
      wr(DTC_MODE_OFFSET, modeT[k]);
      repeat (12) @(posedge linkClock);
      check("strobe", 32'(termDrive.strobeTrueCode), 32'(strT[k]));
      check("strobe comp", 32'(termDrive.strobeCompCode), 32'(strT[k]));
      check("ca", 32'(termDrive.caCode), 32'(caT[k]));
      burst(st, on, fl);
      check("no data term", 32'(st), 32'hFFFF_FFFF);
      check("dq off", 32'(termDrive.dqCode), 32'h0);
    end
    close_out();
  end
endmodule
